//--- logic/beam_eval_pkg.sv
package beam_eval_pkg;

    ////////////////////////////////////////////////////////////////////////
    // geometry
    localparam int N_BEAMS    = 64;
    localparam int BEAM_IDX_W = 6;
    localparam int N_AREAS    = 32;
    localparam int AREA_IDX_W = 5;
    localparam int SPLIT_W    = 3;
    localparam int N_SWITCH   = 4;
    localparam int WORD_W     = 16;
    localparam int SMOOTH_W   = 8;
    localparam int RUN_W      = 8;
    localparam int DELAY_W    = 16;
    localparam int HOLD_W     = 8;
    localparam int CYC_W      = 24;
    localparam int PULSE_W    = 4;

    ////////////////////////////////////////////////////////////////////////
    // encodings and fixed values
    localparam logic [SMOOTH_W-1:0]     SMOOTH_MIN_LEGAL = 8'h01;
    localparam logic [RUN_W-1:0]        RUN_ONE          = 8'h01;
    localparam logic [SPLIT_W-1:0]      SPLIT_MAX        = 3'h5;
    localparam logic [SPLIT_W-1:0]      SPLIT_TOP_SHIFT  = 3'h6;
    localparam logic [BEAM_IDX_W:0]     SPLIT_FULL       = 7'h40;
    localparam logic [AREA_IDX_W:0]     AREA_COUNT_ONE   = 6'h01;
    localparam logic [DELAY_W-1:0]      PERIOD_MIN_US    = 16'h0001;

    ////////////////////////////////////////////////////////////////////////
    // timing: 100 MHz core clock
    localparam int CLK_PERIOD_NS = 10;
    localparam int US_NS         = 1000;
    localparam int TRIG_PULSE_NS = 100;
    localparam logic [CYC_W-1:0] TICK_CYCLES =
        CYC_W'(US_NS / CLK_PERIOD_NS);
    localparam logic [PULSE_W-1:0] TRIG_PULSE_LAST =
        PULSE_W'((TRIG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS - 1);

    ////////////////////////////////////////////////////////////////////////
    // measurement sequencer state
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_DELAY  = 2'b01,
        ST_SMOOTH = 2'b10,
        ST_EVAL   = 2'b11
    } meas_state_t;

    typedef struct packed {
        meas_state_t            st;
        logic [CYC_W-1:0]       dly;
        logic [CYC_W-1:0]       per;
        logic [PULSE_W-1:0]     pls;
        logic                   trig_d;
        logic                   trig_out;
        logic                   busy;
        logic                   done;
        logic [N_BEAMS-1:0]     beam;
        logic [N_BEAMS-1:0]     smooth;
        logic [N_BEAMS-1:0]     stream;
        logic [N_AREAS-1:0]     area;
        logic [HOLD_W-1:0]      hold;
        logic [N_SWITCH-1:0]    sw;
    } meas_regs_t;

    // beams read as free (logic 1) until the first measurement
    localparam meas_regs_t REGS_RST = '{
        st:     ST_IDLE,
        beam:   '1,
        smooth: '1,
        stream: '1,
        default: '0
    };

endpackage : beam_eval_pkg

//--- logic/beam_smoother.sv
`timescale 1ns/1ps
module beam_smoother
    import beam_eval_pkg::*;
(
    input  wire logic [N_BEAMS-1:0]  beam_free,
    input  wire logic [SMOOTH_W-1:0] min_run,
    input  wire logic                invert,
    output logic      [N_BEAMS-1:0]  smooth_free
);

    logic [N_BEAMS-1:0]  member;
    logic [SMOOTH_W-1:0] min_eff;
    logic [RUN_W-1:0]    left_run  [0:N_BEAMS];
    logic [RUN_W-1:0]    right_run [0:N_BEAMS];

    // the filtered class: interrupted beams, or free beams when inverted
    assign member  = invert ? beam_free : ~beam_free;
    // zero is outside the legal range and behaves like one
    assign min_eff = (min_run == '0) ? SMOOTH_MIN_LEGAL : min_run; // RULE5
    assign left_run[0]        = '0;
    assign right_run[N_BEAMS] = '0;

    ////////////////////////////////////////////////////////////////////////
    // run length through each beam from left and right adjacency chains
    for (genvar i = 0; i < N_BEAMS; i++) begin : g_beam
        logic [RUN_W-1:0] run_len;
        logic             keep;
        assign left_run[i+1] = member[i] ? left_run[i] + RUN_ONE : '0;
        assign right_run[i]  = member[i] ? right_run[i+1] + RUN_ONE : '0;
        assign run_len       = left_run[i+1] + right_run[i+1];
        assign keep          = member[i] && (run_len >= min_eff); // RULE2 RULE3 RULE4
        // a short run falls back to the opposite state
        assign smooth_free[i] = invert ? keep : !keep; // RULE6
    end

endmodule : beam_smoother

//--- logic/area_evaluator.sv
`timescale 1ns/1ps
module area_evaluator
    import beam_eval_pkg::*;
(
    input  wire logic [N_BEAMS-1:0]            beam_free,
    input  wire logic [N_AREAS*BEAM_IDX_W-1:0] area_first,
    input  wire logic [N_AREAS*BEAM_IDX_W-1:0] area_last,
    input  wire logic [N_AREAS-1:0]            area_and,
    input  wire logic                          autosplit,
    input  wire logic [SPLIT_W-1:0]            split_log2,
    input  wire logic                          split_and,
    output logic      [N_AREAS-1:0]            area_bits
);

    logic [N_BEAMS-1:0]    intr;
    logic [SPLIT_W-1:0]    s_eff;
    logic [SPLIT_W-1:0]    shift;
    logic [BEAM_IDX_W:0]   span;
    logic [AREA_IDX_W:0]   n_live;

    // area logic works on interrupted beams, the stream carries free ones
    assign intr   = ~beam_free;
    assign s_eff  = (split_log2 > SPLIT_MAX) ? SPLIT_MAX : split_log2;
    assign shift  = SPLIT_TOP_SHIFT - s_eff;
    assign span   = SPLIT_FULL >> s_eff; // RULE15
    assign n_live = AREA_COUNT_ONE << s_eff;

    ////////////////////////////////////////////////////////////////////////
    // one contiguous window per area; windows may touch or overlap
    for (genvar k = 0; k < N_AREAS; k++) begin : g_area
        logic [BEAM_IDX_W-1:0] first;
        logic [BEAM_IDX_W-1:0] last;
        logic                  use_and;
        logic                  live;
        logic [N_BEAMS-1:0]    mask;
        // indices are logical beams, so crossed modes only widen the range
        assign first   = autosplit ? BEAM_IDX_W'(k) << shift
                                   : area_first[k*BEAM_IDX_W +: BEAM_IDX_W]; // RULE13 RULE23
        assign last    = autosplit ? first + BEAM_IDX_W'(span - 7'h01)
                                   : area_last[k*BEAM_IDX_W +: BEAM_IDX_W]; // RULE13
        assign use_and = autosplit ? split_and : area_and[k]; // RULE17
        assign live    = autosplit ? ((AREA_IDX_W+1)'(k) < n_live) : 1'b1;
        for (genvar j = 0; j < N_BEAMS; j++) begin : g_mask
            assign mask[j] = (BEAM_IDX_W'(j) >= first) && (BEAM_IDX_W'(j) <= last); // RULE20
        end
        // an inverted window (first above last) never switches
        assign area_bits[k] = live && (first <= last) &&
                              (use_and ? &(intr | ~mask)       // RULE18 RULE22
                                       : |(intr & mask));      // RULE19 RULE22
    end

endmodule : area_evaluator

//--- logic/beam_state_evaluation.sv
// Operation
// RULE1: a free beam is 1, an interrupted beam is 0 in the beam vector
// RULE2: with smoothing, interrupted beams count only in runs reaching the minimum
// RULE3: minimum of one evaluates every interrupted beam on its own
// RULE4: minimum three drops runs shorter than three, reporting them as free
// RULE5: smoothing minimum accepts values one through 255
// RULE6: inverted smoothing keeps free beams only in runs reaching the minimum
// RULE7: external mode starts a measurement on a trigger input pulse
// RULE8: each unit measures after its own delay counted from the trigger
// RULE9: an internal master emits trigger pulses continuously, no controller needed
// RULE10: slaves fed by the master pulse start after their configured delay
// RULE11: a mode input selects internal or external trigger activation
// RULE12: up to 32 area bits, readable as 16-bit or 32-bit word
// RULE13: an area is a first beam, last beam and link condition
// RULE14: hold applies to area bits as well as the beam stream
// RULE15: autosplit divides all beams into the chosen number of equal areas
// RULE16: autosplit area states appear as an upper and a lower 16-bit word
// RULE17: autosplit links beams inside each area by AND or OR
// RULE18: AND gives 1 only when every mapped beam is interrupted
// RULE19: OR gives 1 when at least one mapped beam is interrupted
// RULE20: areas may be adjacent or overlap, beams feed several areas
// RULE21: a switching output follows any chosen area bit
// RULE22: whole-field area switches on one beam for OR, all for AND
// RULE23: the configurer gives area limits in logical beams for crossed modes
// RULE24: smoothing runs before area evaluation so all areas share one vector
`timescale 1ns/1ps
module beam_state_evaluation
    import beam_eval_pkg::*;
(
    input  wire logic                            CORE_CLK,
    input  wire logic                            RST_B,
    input  wire logic [N_BEAMS-1:0]              BEAM_FREE,
    input  wire logic                            TRIG_IN,
    input  wire logic                            TRIG_INTERNAL,
    input  wire logic                            TRIG_MASTER,
    input  wire logic [DELAY_W-1:0]              TRIG_DELAY_US,
    input  wire logic [DELAY_W-1:0]              TRIG_PERIOD_US,
    input  wire logic [SMOOTH_W-1:0]             SMOOTH_MIN,
    input  wire logic                            SMOOTH_INVERT,
    input  wire logic [N_AREAS*BEAM_IDX_W-1:0]   AREA_FIRST,
    input  wire logic [N_AREAS*BEAM_IDX_W-1:0]   AREA_LAST,
    input  wire logic [N_AREAS-1:0]              AREA_AND,
    input  wire logic                            AUTOSPLIT_EN,
    input  wire logic [SPLIT_W-1:0]              AUTOSPLIT_LOG2,
    input  wire logic                            AUTOSPLIT_AND,
    input  wire logic [HOLD_W-1:0]               HOLD_MEAS,
    input  wire logic [N_SWITCH*AREA_IDX_W-1:0]  SWITCH_SEL,
    output logic                                 TRIG_OUT,
    output logic                                 MEAS_BUSY,
    output logic                                 MEAS_DONE,
    output logic      [N_BEAMS-1:0]              BEAM_STREAM,
    output logic      [WORD_W-1:0]               AREA_STATE_UPPER_WORD,
    output logic      [WORD_W-1:0]               AREA_STATE_LOWER_WORD,
    output logic      [N_SWITCH-1:0]             SWITCH_OUT
);

    meas_regs_t          state_r;
    meas_regs_t          state_nxt;
    logic [N_BEAMS-1:0]  smooth_w;
    logic [N_AREAS-1:0]  area_w;
    logic [N_AREAS-1:0]  area_nxt;
    logic [N_SWITCH-1:0] sw_w;
    logic [CYC_W-1:0]    dly_load;
    logic [CYC_W-1:0]    per_load;
    logic [DELAY_W-1:0]  period_us;
    logic                master_on;
    logic                ext_edge;
    logic                self_trig;
    logic                go;

    ////////////////////////////////////////////////////////////////////////
    // datapath: smoothing of the captured vector, then areas on the result
    beam_smoother u_smoother (
        .beam_free   (state_r.beam),
        .min_run     (SMOOTH_MIN),
        .invert      (SMOOTH_INVERT),
        .smooth_free (smooth_w)
    );

    // areas read the registered smoothed vector only
    area_evaluator u_areas (
        .beam_free  (state_r.smooth), // RULE24
        .area_first (AREA_FIRST),
        .area_last  (AREA_LAST),
        .area_and   (AREA_AND),
        .autosplit  (AUTOSPLIT_EN),
        .split_log2 (AUTOSPLIT_LOG2),
        .split_and  (AUTOSPLIT_AND),
        .area_bits  (area_w)
    );

    ////////////////////////////////////////////////////////////////////////
    // trigger timing in core cycles; products stay below 2^24
    assign period_us = (TRIG_PERIOD_US == '0) ? PERIOD_MIN_US : TRIG_PERIOD_US;
    assign dly_load  = CYC_W'(TRIG_DELAY_US) * TICK_CYCLES;
    assign per_load  = CYC_W'(period_us) * TICK_CYCLES - CYC_W'(1);
    assign master_on = TRIG_INTERNAL && TRIG_MASTER;
    assign ext_edge  = TRIG_IN && !state_r.trig_d;
    assign self_trig = master_on && (state_r.per == '0);
    // a master ignores its input pin and starts on its own pulse
    assign go        = master_on ? self_trig : ext_edge; // RULE11 RULE7 RULE10

    // switching outputs pick any of the held area bits
    assign area_nxt = state_nxt.area;
    for (genvar q = 0; q < N_SWITCH; q++) begin : g_switch
        assign sw_w[q] = area_nxt[SWITCH_SEL[q*AREA_IDX_W +: AREA_IDX_W]]; // RULE21
    end

    ////////////////////////////////////////////////////////////////////////
    // next-state logic: pulse generator, sequencer, hold accumulation
    always_comb begin
        state_nxt        = state_r;
        state_nxt.trig_d = TRIG_IN;
        state_nxt.done   = 1'b0;
        // trigger pulse width runs out independently of the mode inputs
        if (state_r.pls != '0) begin
            state_nxt.pls = state_r.pls - PULSE_W'(1);
        end else begin
            state_nxt.trig_out = 1'b0;
        end
        if (master_on) begin
            if (self_trig) begin
                state_nxt.per      = per_load; // RULE9
                state_nxt.pls      = TRIG_PULSE_LAST;
                state_nxt.trig_out = 1'b1;
            end else begin
                state_nxt.per = state_r.per - CYC_W'(1);
            end
        end else begin
            // first pulse leaves right after master mode is enabled
            state_nxt.per = '0;
        end
        unique case (state_r.st)
            ST_IDLE: begin
                // triggers during a running measurement are dropped
                if (go) begin
                    state_nxt.st   = ST_DELAY;
                    state_nxt.dly  = dly_load; // RULE8
                    state_nxt.busy = 1'b1;
                end
            end
            ST_DELAY: begin
                if (state_r.dly == '0) begin
                    state_nxt.beam = BEAM_FREE; // RULE1
                    state_nxt.st   = ST_SMOOTH;
                end else begin
                    state_nxt.dly = state_r.dly - CYC_W'(1);
                end
            end
            ST_SMOOTH: begin
                state_nxt.smooth = smooth_w; // RULE24
                state_nxt.st     = ST_EVAL;
            end
            ST_EVAL: begin
                // a window restarts with fresh data, otherwise extremes stick
                if (state_r.hold == '0) begin
                    state_nxt.area   = area_w;
                    state_nxt.stream = state_r.smooth;
                end else begin
                    state_nxt.area   = state_r.area | area_w; // RULE14
                    state_nxt.stream = state_r.stream & state_r.smooth; // RULE14
                end
                state_nxt.hold = (state_r.hold >= HOLD_MEAS) ? '0
                                 : state_r.hold + HOLD_W'(1);
                state_nxt.st   = ST_IDLE;
                state_nxt.busy = 1'b0;
                state_nxt.done = 1'b1;
            end
        endcase
        state_nxt.sw = sw_w;
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            state_r <= REGS_RST;
        end else begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, all straight from the state register
    assign TRIG_OUT              = state_r.trig_out;
    assign MEAS_BUSY             = state_r.busy;
    assign MEAS_DONE             = state_r.done;
    assign BEAM_STREAM           = state_r.stream;
    assign AREA_STATE_UPPER_WORD = state_r.area[N_AREAS-1:WORD_W]; // RULE12 RULE16
    assign AREA_STATE_LOWER_WORD = state_r.area[WORD_W-1:0]; // RULE12 RULE16
    assign SWITCH_OUT            = state_r.sw;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_B);

    chk_ext_start_now: assert property ( // RULE7
        (state_r.st == ST_IDLE && go && TRIG_DELAY_US == 16'h0000)
            |=> state_r.st == ST_DELAY ##1 state_r.st == ST_SMOOTH ##2 MEAS_DONE)
        else $error("external trigger did not give a result four cycles on");

    chk_delay_one_us: assert property ( // RULE8
        (state_r.st == ST_IDLE && go && TRIG_DELAY_US == 16'h0001)
            |-> ##1 MEAS_BUSY ##103 MEAS_DONE)
        else $error("one microsecond delay not honoured");

    chk_master_pulse: assert property ( // RULE9
        $rose(TRIG_OUT) |-> TRIG_OUT[*8] ##1 TRIG_OUT[*2] ##1 !TRIG_OUT)
        else $error("master trigger pulse is not ten cycles wide");

    chk_slave_follow: assert property ( // RULE10
        (state_r.st == ST_IDLE && TRIG_INTERNAL && !TRIG_MASTER && ext_edge)
            |=> MEAS_BUSY && state_r.st == ST_DELAY)
        else $error("slave ignored trigger from master");

    chk_master_pin_off: assert property ( // RULE11
        (state_r.st == ST_IDLE && master_on && ext_edge && state_r.per != '0)
            |=> !MEAS_BUSY)
        else $error("master started from its input pin");

    chk_smooth_one: assert property ( // RULE3
        (state_r.st == ST_SMOOTH && SMOOTH_MIN == 8'h01 && !SMOOTH_INVERT)
            |=> state_r.smooth == $past(state_r.beam))
        else $error("smoothing one altered the beam vector");

    chk_smooth_subset: assert property ( // RULE2
        (state_r.st == ST_SMOOTH && !SMOOTH_INVERT)
            |-> (~smooth_w & state_r.beam) == '0)
        else $error("smoothing invented an interrupted beam");

    chk_smooth_iso: assert property ( // RULE4
        (state_r.st == ST_SMOOTH && !SMOOTH_INVERT && SMOOTH_MIN == 8'h03
            && $countones(~state_r.beam) == 2) |-> &smooth_w)
        else $error("run shorter than three was reported");

    chk_inv_subset: assert property ( // RULE6
        (state_r.st == ST_SMOOTH && SMOOTH_INVERT)
            |-> (smooth_w & ~state_r.beam) == '0)
        else $error("inverted smoothing invented a free beam");

    chk_and_whole: assert property ( // RULE18
        (state_r.st == ST_EVAL && AUTOSPLIT_EN && AUTOSPLIT_LOG2 == 3'h0 && AUTOSPLIT_AND)
            |-> area_w[0] == (state_r.smooth == '0))
        else $error("AND area bit wrong over whole field");

    chk_or_whole: assert property ( // RULE19
        (state_r.st == ST_EVAL && AUTOSPLIT_EN && AUTOSPLIT_LOG2 == 3'h0 && !AUTOSPLIT_AND)
            |-> area_w[0] == (state_r.smooth != '1))
        else $error("OR area bit wrong over whole field");

    chk_split_live: assert property ( // RULE15
        (state_r.st == ST_EVAL && AUTOSPLIT_EN && AUTOSPLIT_LOG2 == 3'h4)
            |-> area_w[N_AREAS-1:WORD_W] == '0)
        else $error("area beyond the split count is active");

    chk_hold_pass: assert property ( // RULE14
        (state_r.st == ST_EVAL && HOLD_MEAS == 8'h00)
            |=> {AREA_STATE_UPPER_WORD, AREA_STATE_LOWER_WORD} == $past(area_w)
                && BEAM_STREAM == $past(state_r.smooth))
        else $error("hold zero did not pass the result through");

    chk_switch_map: assert property ( // RULE21
        MEAS_DONE |-> SWITCH_OUT[0] == state_r.area[$past(SWITCH_SEL[AREA_IDX_W-1:0])])
        else $error("switching output does not follow its area");

    cov_master_cycle: cover property (master_on && MEAS_DONE);
    cov_delayed_slave: cover property (!master_on && TRIG_DELAY_US != '0 && MEAS_DONE);
    cov_inverted: cover property (SMOOTH_INVERT && MEAS_DONE && BEAM_STREAM != '1);
    cov_split_32: cover property (AUTOSPLIT_EN && AUTOSPLIT_LOG2 == 3'h5 && MEAS_DONE);

endmodule : beam_state_evaluation

//--- bench/trig_source.sv
`timescale 1ns/1ps
module trig_source (
    input  wire logic clk,
    input  wire logic fire,
    output logic      trig
);
    // controller pulse, two cycles wide; line stays low between pulses
    logic [1:0] cnt_r = 2'h0;
    always_ff @(posedge clk) begin
        if (fire) begin
            cnt_r <= 2'h2;
        end else if (cnt_r != 2'h0) begin
            cnt_r <= cnt_r - 2'h1;
        end
    end
    assign trig = (cnt_r != 2'h0);
endmodule : trig_source

//--- bench/beam_state_evaluation_tb.sv
`timescale 1ns/1ps
module beam_state_evaluation_tb;
    import beam_eval_pkg::*;
    logic                           CORE_CLK, RST_B, TRIG_IN, fire;
    logic                           TRIG_INTERNAL, TRIG_MASTER, SMOOTH_INVERT;
    logic                           AUTOSPLIT_EN, AUTOSPLIT_AND;
    logic [N_BEAMS-1:0]             BEAM_FREE, BEAM_STREAM;
    logic [DELAY_W-1:0]             TRIG_DELAY_US, TRIG_PERIOD_US;
    logic [SMOOTH_W-1:0]            SMOOTH_MIN;
    logic [N_AREAS*BEAM_IDX_W-1:0]  AREA_FIRST, AREA_LAST;
    logic [N_AREAS-1:0]             AREA_AND;
    logic [SPLIT_W-1:0]             AUTOSPLIT_LOG2;
    logic [HOLD_W-1:0]              HOLD_MEAS;
    logic [N_SWITCH*AREA_IDX_W-1:0] SWITCH_SEL;
    logic                           TRIG_OUT, MEAS_BUSY, MEAS_DONE;
    logic [WORD_W-1:0]              AREA_STATE_UPPER_WORD, AREA_STATE_LOWER_WORD;
    logic [N_SWITCH-1:0]            SWITCH_OUT;
    int                             error_cnt, samples_checked, n, hi, lo, dn;

    beam_state_evaluation i_dut (.*);
    trig_source i_src (.clk(CORE_CLK), .fire(fire), .trig(TRIG_IN));

    //////////////////////////////
    initial begin
        CORE_CLK = 1'b0;
        forever #5 CORE_CLK = ~CORE_CLK;
    end

    task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
            error_cnt++;
        end
    endtask : check

    // one triggered measurement; n counts edges from the request to the done pulse
    task automatic run(input logic [63:0] fr, output int cnt);
        @(posedge CORE_CLK);
        BEAM_FREE <= fr;
        fire      <= 1'b1;
        @(posedge CORE_CLK);
        fire <= 1'b0;
        cnt = 1;
        #1;
        while (MEAS_DONE !== 1'b1 && cnt < 400) begin
            if (cnt == 2) begin
                check("meas busy", MEAS_BUSY, 1'b1);
            end
            @(posedge CORE_CLK);
            #1;
            cnt++;
        end
        check("busy after done", MEAS_BUSY, 1'b0);
    endtask : run

    task automatic ev(input logic [63:0] fr, input logic [63:0] st, input logic [31:0] ar);
        int c;
        run(fr, c);
        check("beam stream", BEAM_STREAM, st);
        check("area words", {AREA_STATE_UPPER_WORD, AREA_STATE_LOWER_WORD}, ar);
    endtask : ev

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop

    // generous bound: the whole sequence needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge CORE_CLK);
        error_cnt++;
        report_and_stop();
    end

    //////////////////////////////
    initial begin
        // areas: 0 whole field OR, 1 whole field AND, 2 beams 0..23 AND, 3 beams 10..30 OR
        AREA_FIRST     <= {{28{6'h01}}, 6'h0A, 6'h00, 6'h00, 6'h00};
        AREA_LAST      <= {{28{6'h00}}, 6'h1E, 6'h17, 6'h3F, 6'h3F};
        AREA_AND       <= 32'h0000_0006;
        SWITCH_SEL     <= {5'h03, 5'h02, 5'h01, 5'h00};
        RST_B <= 1'b0; fire <= 1'b0; BEAM_FREE <= '1; TRIG_INTERNAL <= 1'b0;
        TRIG_MASTER <= 1'b0; TRIG_DELAY_US <= 16'h0000; TRIG_PERIOD_US <= 16'h0001;
        SMOOTH_MIN <= 8'h01; SMOOTH_INVERT <= 1'b0; AUTOSPLIT_EN <= 1'b0;
        AUTOSPLIT_LOG2 <= 3'h5; AUTOSPLIT_AND <= 1'b0; HOLD_MEAS <= 8'h00;
        repeat (3) @(posedge CORE_CLK);
        RST_B <= 1'b1;
        // manual areas, no smoothing
        run(~64'h20, n);
        check("done latency", n, 5);
        check("beam stream", BEAM_STREAM, ~64'h20);
        check("area words", AREA_STATE_LOWER_WORD, 16'h0001);
        check("switch out", SWITCH_OUT, 4'h1);
        ev(~64'hFF_FFFF, ~64'hFF_FFFF, 32'hD);
        check("switch out", SWITCH_OUT, 4'hD);
        ev(~64'h7F_FFFF, ~64'h7F_FFFF, 32'h9);
        ev(64'h0, 64'h0, 32'hF);
        // two-measurement hold window: areas OR together, the stream ANDs
        HOLD_MEAS <= 8'h01;
        ev(~64'h20, ~64'h20, 32'h1);
        ev(~64'h100_0000, ~64'h100_0020, 32'h9);
        HOLD_MEAS <= 8'h00;
        // short interrupted runs vanish, and areas only see the filtered vector
        @(posedge CORE_CLK);
        SMOOTH_MIN <= 8'h03;
        ev(~64'h60, '1, 32'h0);
        ev(~64'h70_0060, ~64'h70_0000, 32'h9);
        @(posedge CORE_CLK);
        SMOOTH_MIN <= 8'hFF;
        ev(64'h0, '1, 32'h0);
        @(posedge CORE_CLK);
        SMOOTH_MIN    <= 8'h03;
        SMOOTH_INVERT <= 1'b1;
        ev(64'h0700_0000_0060, 64'h0700_0000_0000, 32'hD);
        @(posedge CORE_CLK);
        SMOOTH_MIN    <= 8'h01;
        SMOOTH_INVERT <= 1'b0;
        AUTOSPLIT_EN  <= 1'b1;
        ev(~64'h4000_0000_0000_0005, ~64'h4000_0000_0000_0005, 32'h8000_0003);
        @(posedge CORE_CLK);
        AUTOSPLIT_AND <= 1'b1;
        ev(~64'hC000_0000_0000_0003, ~64'hC000_0000_0000_0003, 32'h8000_0001);
        @(posedge CORE_CLK);
        AUTOSPLIT_AND  <= 1'b0;
        AUTOSPLIT_LOG2 <= 3'h4;
        ev(~64'h8000_0000_0000_0000, ~64'h8000_0000_0000_0000, 32'h8000);
        @(posedge CORE_CLK);
        AUTOSPLIT_EN  <= 1'b0;
        TRIG_DELAY_US <= 16'h0001;
        run('1, n);
        check("delayed latency", n, 105);
        // master mode: own pulse train, one measurement per period
        @(posedge CORE_CLK);
        TRIG_DELAY_US <= 16'h0000;
        TRIG_INTERNAL <= 1'b1;
        TRIG_MASTER   <= 1'b1;
        n  = 0;
        hi = 0;
        lo = 0;
        dn = 0;
        do begin
            @(posedge CORE_CLK);
            #1;
            n++;
        end while (TRIG_OUT !== 1'b1 && n < 120);
        while (TRIG_OUT === 1'b1 && hi < 50) begin
            dn += (MEAS_DONE === 1'b1);
            @(posedge CORE_CLK);
            #1;
            hi++;
        end
        while (TRIG_OUT !== 1'b1 && lo < 300) begin
            dn += (MEAS_DONE === 1'b1);
            // a pin pulse in master mode must not start a second measurement
            fire <= (lo == 10);
            @(posedge CORE_CLK);
            #1;
            lo++;
        end
        check("pulse width", hi, 10);
        check("pulse period", hi + lo, 100);
        check("master measurements", dn, 1);
        TRIG_MASTER   <= 1'b0;
        // let the last master measurement finish before the slave run
        repeat (20) @(posedge CORE_CLK);
        run('1, n);
        check("slave latency", n, 5);
        report_and_stop();
    end
endmodule : beam_state_evaluation_tb
